// file: ddct_pkg.sv
// Package for the dual down-counter timer block: map, fields, timing.
// Assumes a 125 MHz pclk and a 32-bit APB master.
package ddct_pkg;
   // Register byte addresses (data bytes at 0x60, 0x64, 0x68, command at 0x6c)
   localparam logic [7:0] ADDR_DATA_LOW = 8'h60;
   localparam logic [7:0] ADDR_DATA_MID = 8'h64;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'h68;
   localparam logic [7:0] ADDR_COUNTER_COMMAND = 8'h6c;
   localparam logic [7:0] ADDR_CONFIG = 8'h30;
   localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h38;
   localparam int IDX_DATA_LOW = 24;
   localparam int IDX_DATA_MID = 25;
   localparam int IDX_DATA_HIGH = 26;
   localparam int IDX_COUNTER_COMMAND = 27;
   // Command bits
   localparam int CMD_CLEAR = 0;
   localparam int CMD_LOAD = 1;
   localparam int CMD_CT_EN = 2;
   localparam int CMD_CT_DIS = 3;
   localparam int CMD_GT_EN = 4;
   localparam int CMD_GT_DIS = 5;
   localparam int CMD_LATCH = 6;
   localparam int CMD_SELECT = 7;
   // Configuration bits
   localparam int CFG_SAMPLE_FREQ = 0;
   localparam int CFG_EVENT_FREQ = 1;
   localparam int CFG_EVENT_SRC = 2;
   localparam int CFG_LOWER_E = 4;
   localparam int CFG_UPPER_E = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Analog control bits
   localparam int ACT_CONVERSION_CLOCK_SELECT = 1;
   localparam int ACT_ANALOG_INTERRUPT_ENABLE = 0;
   // Width
   localparam int SAMPLE_W = 24;
   localparam int EVENT_W = 16;
   // Tick timing from pclk
   localparam int PCLK_HZ = 125_000_000;
   localparam int FAST_HZ = 10_000_000;
   localparam int SLOW_HZ = 100_000;
   localparam int FAST_DIV = PCLK_HZ / FAST_HZ;
   localparam int SLOW_DIV = PCLK_HZ / SLOW_HZ;
   localparam logic [10:0] FAST_LAST = 11'(FAST_DIV - 1);
   localparam logic [10:0] SLOW_LAST = 11'(SLOW_DIV - 1);

   typedef struct packed {
      logic enabled;
      logic gated;
      logic [23:0] count;
      logic [23:0] load;
      logic [23:0] latched;
      logic pulse;
   } ddct_ctr_s;

   typedef struct packed {
      logic gate;
      logic tick;
   } ddct_tick_s;
endpackage

// file: ddct_tickgen.sv
// Tick generator: 10 MHz and 100 kHz one-cycle enables from pclk.
// Assumes pclk at the package rate; the fast tick comes every 12 cycles, slightly above 10 MHz.
module ddct_tickgen (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Ticks
   output logic fast_tick,
   output logic slow_tick
);
   import ddct_pkg::*;

   typedef struct packed {
      logic [10:0] fast_cnt;
      logic [10:0] slow_cnt;
      logic fast;
      logic slow;
   } ddct_tg_s;

   ddct_tg_s st, next_st;

   // 12.5 cycles per fast tick; we round to 12, a small rate error
   always_comb begin
      next_st = st;
      next_st.fast = (st.fast_cnt == FAST_LAST);
      next_st.slow = (st.slow_cnt == SLOW_LAST);
      next_st.fast_cnt = next_st.fast ? 11'h000 : st.fast_cnt + 11'h001;
      next_st.slow_cnt = next_st.slow ? 11'h000 : st.slow_cnt + 11'h001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fast_tick = st.fast;
   assign slow_tick = st.slow;
endmodule

// file: ddct_top.sv
// Dual down-counter timer: 24-bit sample-rate and 16-bit event counters.
// Assumes APB master on pclk; external pins are asynchronous.
// Overview of operation
// - 24-bit counter pulses at zero, reloads
// - Sample clock 10MHz or 100kHz by bit0
// - Sample gate from port E4 when bit5
// - Sample pulse always on dedicated output
// - Sample pulse triggers conversions when enabled and clock select is 0
// - Divisors from 2 to 16777215 accepted
// - Event counter 16-bit with count, gate
// - Event on-board clock selected by bit1
// - Source select counts external rising edges
// - Event output high at zero until reload
// - Gated counter counts only while gate high
// - Upper select zero: onboard clock, no gate
// - Command bits select latch gate enable load clear
// - Latch captures count without stopping it
// - Enable and disable anytime; disabled ignores edges
// - Gating off counts every edge
// - Load bytes written in any order
// - Upper port E carries counter functions
// - Clear zeros counter; keeps counting if enabled
// - Latched bytes low middle high per counter
module ddct_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input wire logic [7:4] port_e_in,
   input wire logic external_count_in,
   // Pin outputs
   output logic sample_rate_pulse_out,
   output logic [7:4] port_e_out,
   output logic [7:4] port_e_oe,
   output logic [7:4] port_e_dio_out,
   output logic [7:4] port_e_dio_oe,
   output logic dio_latch_in,
   // Analog timing
   output logic conversion_trigger
);
   import ddct_pkg::*;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] config_reg;
      logic [1:0] analog_ctrl;
      logic [23:0] data_wr;
      logic view_c1;
      ddct_ctr_s c0;
      ddct_ctr_s c1;
      logic [1:0] sample_rate_gate_in_sync;
      logic [1:0] event_counter_gate_in_sync;
      logic [1:0] ext_sync;
      logic [1:0] latch_sync;
      logic ext_prev;
      logic s_out;
      logic [7:4] pe_out;
      logic [7:4] pe_oe;
      logic [7:4] dio_o;
      logic [7:4] dio_oe;
      logic dlatch;
      logic conv;
   } ddct_state_s;

   ddct_state_s st, next_st;
   logic fast_tick;
   logic slow_tick;

   ddct_tickgen u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .fast_tick(fast_tick),
      .slow_tick(slow_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Address decode used by read and write paths
   function automatic logic [2:0] decode(input logic [7:0] a);
      if (a == ADDR_DATA_LOW) begin
         decode = 3'h1;
      end else if (a == ADDR_DATA_MID) begin
         decode = 3'h2;
      end else if (a == ADDR_DATA_HIGH) begin
         decode = 3'h3;
      end else if (a == ADDR_COUNTER_COMMAND) begin
         decode = 3'h4;
      end else if (a == ADDR_CONFIG) begin
         decode = 3'h5;
      end else if (a == ADDR_ANALOG_CTRL) begin
         decode = 3'h6;
      end else if (a == ADDR_STATUS) begin
         decode = 3'h7;
      end else begin
         decode = 3'h0;
      end
   endfunction

   // One counter step; width masks the event counter to 16 bits
   // Pulses change only on a tick, so each spans one input period
   function automatic ddct_ctr_s step(input ddct_ctr_s c,
                                      input logic tick,
                                      input logic [23:0] mask,
                                      input logic early_reload);
      ddct_ctr_s r;
      r = c;
      if (tick) begin
         if (c.count == 24'h000000) begin
            r.count = c.load & mask;
            r.pulse = 1'b0;
         end else if (early_reload && (c.count == 24'h000001)) begin
            // Divide by n: reload on the tick that reaches zero
            r.count = c.load & mask;
            r.pulse = 1'b1;
         end else begin
            r.count = (c.count - 24'h000001) & mask;
            r.pulse = (r.count == 24'h000000);
         end
      end
      step = r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   logic acc;
   logic [2:0] sel;
   logic upper;
   logic c0_src;
   logic c1_src;
   logic c0_tick;
   logic c1_tick;
   logic [7:0] cmd;
   logic ext_rise;
   logic wr_now;
   logic [23:0] view;

   always_comb begin
      next_st = st;
      acc = psel && penable && !st.pready;
      sel = decode(paddr);
      cmd = pwdata[7:0];
      upper = st.config_reg[CFG_UPPER_E];
      // Writes land at the edge where the master sees pready high
      wr_now = psel && penable && pwrite && st.pready;
      // Data bytes show whichever counter was latched last
      view = st.view_c1 ? {8'h00, st.c1.latched[15:0]} : st.c0.latched;

      // Synchronisers: only stage 1 reads stage 0
      next_st.sample_rate_gate_in_sync = {st.sample_rate_gate_in_sync[0], port_e_in[4]};
      next_st.latch_sync = {st.latch_sync[0], port_e_in[5]};
      next_st.event_counter_gate_in_sync = {st.event_counter_gate_in_sync[0], port_e_in[7]};
      next_st.ext_sync = {st.ext_sync[0], external_count_in};
      next_st.ext_prev = st.ext_sync[1];
      ext_rise = st.ext_sync[1] && !st.ext_prev;

      // APB: one wait state, answer on second access cycle
      next_st.pready = acc;
      next_st.pslverr = 1'b0;
      if (acc && !pwrite) begin
         case (sel)
            3'h1: next_st.prdata = {24'h000000, view[7:0]};
            3'h2: next_st.prdata = {24'h000000, view[15:8]};
            3'h3: next_st.prdata = {24'h000000, view[23:16]};
            3'h5: next_st.prdata = {24'h000000, st.config_reg};
            3'h6: next_st.prdata = {30'h00000000, st.analog_ctrl};
            3'h7: next_st.prdata = {28'h0000000, st.c1.pulse, st.c0.pulse,
                                    st.c1.enabled, st.c0.enabled};
            default: next_st.prdata = 32'h00000000;
         endcase
         next_st.pslverr = (sel == 3'h0);
      end else if (acc) begin
         next_st.prdata = 32'h00000000;
         next_st.pslverr = (sel == 3'h0);
      end

      // Clock selection
      c0_src = st.config_reg[CFG_SAMPLE_FREQ] ? slow_tick : fast_tick;
      c1_src = st.config_reg[CFG_EVENT_FREQ] ? slow_tick : fast_tick;
      if (upper && st.config_reg[CFG_EVENT_SRC]) begin
         c1_src = ext_rise;
      end
      // Gate only honoured when upper port E carries counter pins
      c0_tick = c0_src && st.c0.enabled &&
                (!(upper && st.c0.gated) || st.sample_rate_gate_in_sync[1]);
      c1_tick = c1_src && st.c1.enabled &&
                (!(upper && st.c1.gated) || st.event_counter_gate_in_sync[1]);

      next_st.c0 = step(st.c0, c0_tick, 24'hffffff, 1'b1);
      next_st.c1 = step(st.c1, c1_tick, 24'h00ffff, 1'b0);

      // Register writes
      if (wr_now) begin
         case (sel)
            3'h1: next_st.data_wr[7:0] = pwdata[7:0];
            3'h2: next_st.data_wr[15:8] = pwdata[7:0];
            3'h3: next_st.data_wr[23:16] = pwdata[7:0];
            3'h5: next_st.config_reg = pwdata[7:0];
            3'h6: next_st.analog_ctrl = pwdata[1:0];
            3'h4: begin
               // Commands decoded bit by bit; selected counter only
               if (!cmd[CMD_SELECT]) begin
                  if (cmd[CMD_CLEAR]) begin
                     next_st.c0.count = 24'h000000;
                  end
                  if (cmd[CMD_LOAD]) begin
                     next_st.c0.load = st.data_wr;
                     next_st.c0.count = st.data_wr;
                  end
                  if (cmd[CMD_CT_EN]) begin
                     next_st.c0.enabled = 1'b1;
                  end
                  if (cmd[CMD_CT_DIS]) begin
                     next_st.c0.enabled = 1'b0;
                  end
                  if (cmd[CMD_GT_EN]) begin
                     next_st.c0.gated = 1'b1;
                  end
                  if (cmd[CMD_GT_DIS]) begin
                     next_st.c0.gated = 1'b0;
                  end
                  if (cmd[CMD_LATCH]) begin
                     next_st.c0.latched = st.c0.count;
                     next_st.view_c1 = 1'b0;
                  end
               end else begin
                  if (cmd[CMD_CLEAR]) begin
                     next_st.c1.count = 24'h000000;
                  end
                  if (cmd[CMD_LOAD]) begin
                     next_st.c1.load = {8'h00, st.data_wr[15:0]};
                     next_st.c1.count = {8'h00, st.data_wr[15:0]};
                  end
                  if (cmd[CMD_CT_EN]) begin
                     next_st.c1.enabled = 1'b1;
                  end
                  if (cmd[CMD_CT_DIS]) begin
                     next_st.c1.enabled = 1'b0;
                  end
                  if (cmd[CMD_GT_EN]) begin
                     next_st.c1.gated = 1'b1;
                  end
                  if (cmd[CMD_GT_DIS]) begin
                     next_st.c1.gated = 1'b0;
                  end
                  if (cmd[CMD_LATCH]) begin
                     // Own copy per counter; reads follow the last latch
                     next_st.c1.latched = {8'h00, st.c1.count[15:0]};
                     next_st.view_c1 = 1'b1;
                  end
               end
            end
            default: next_st.prdata = st.prdata;
         endcase
      end
      // Latched value otherwise untouched until next latch

      // Pins
      next_st.s_out = next_st.c0.pulse;
      // One trigger per sample pulse, however long the pulse stands
      next_st.conv = next_st.c0.pulse && !st.c0.pulse &&
                     st.analog_ctrl[ACT_ANALOG_INTERRUPT_ENABLE] &&
                     !st.analog_ctrl[ACT_CONVERSION_CLOCK_SELECT];
      next_st.dlatch = upper ? st.latch_sync[1] : 1'b1;
      if (upper) begin
         // E4,E5,E7 inputs; E6 carries event output
         next_st.pe_out = {1'b0, next_st.c1.pulse, 2'b00};
         next_st.pe_oe = 4'b0100;
         next_st.dio_o = 4'h0;
         next_st.dio_oe = 4'h0;
      end else begin
         next_st.pe_out = 4'h0;
         next_st.pe_oe = 4'h0;
         next_st.dio_o = 4'hf; // Pass-through flag for ordinary DIO
         next_st.dio_oe = 4'hf;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.dlatch <= 1'b1;
         // Config resets to zero, so ordinary DIO owns port E
         st.dio_o <= 4'hf;
         st.dio_oe <= 4'hf;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign sample_rate_pulse_out = st.s_out;
   assign port_e_out = st.pe_out;
   assign port_e_oe = st.pe_oe;
   assign port_e_dio_out = st.dio_o;
   assign port_e_dio_oe = st.dio_oe;
   assign dio_latch_in = st.dlatch;
   assign conversion_trigger = st.conv;
endmodule

// file: ddct_top_properties.sv
// Checker for the dual down-counter timer pins and APB answer.
// Assumes it is bound to ddct_top and sees only its ports.
module ddct_top_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic sample_rate_pulse_out,
   input wire logic conversion_trigger,
   input wire logic [7:4] port_e_out,
   input wire logic [7:4] port_e_oe,
   input wire logic [7:4] port_e_dio_oe,
   input wire logic dio_latch_in
);
   import ddct_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // A pulse changes only on a tick, so it spans a whole tick period
   a_pulse_width: assert property ($rose(sample_rate_pulse_out) |->
      sample_rate_pulse_out [*8]) else $error("sample pulse too short");
   // Divisor 2 still leaves one whole tick low between pulses
   a_pulse_spacing: assert property ($fell(sample_rate_pulse_out) |->
      !sample_rate_pulse_out [*8]) else $error("sample pulses too close");
   a_trigger_cause: assert property (conversion_trigger |->
      $rose(sample_rate_pulse_out))
      else $error("trigger not at sample pulse start");
   a_event_hold: assert property ($rose(port_e_out[6]) && port_e_oe[6] |=>
      port_e_out[6] [*3]) else $error("event output dropped early");
   a_oe_pattern: assert property (port_e_oe == 4'h0 ||
      port_e_oe == 4'h4) else $error("bad port E enable");
   a_dio_release: assert property (port_e_oe[6] |->
      port_e_dio_oe == 4'h0) else $error("DIO still drives port E");
   a_latch_idle: assert property (!port_e_oe[6] |-> dio_latch_in)
      else $error("latch input not idle");
   a_apb_answer: assert property (psel && penable && !pready |=>
      pready) else $error("APB answer late");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   c_pulse: cover property ($rose(sample_rate_pulse_out));
   c_event: cover property ($rose(port_e_out[6]));
   c_error: cover property (pslverr);
   c_trigger: cover property (conversion_trigger);
endmodule

bind ddct_top ddct_top_properties u_props (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .sample_rate_pulse_out, .conversion_trigger,
   .port_e_out, .port_e_oe, .port_e_dio_oe, .dio_latch_in);

// file: ddct_pins_model.sv
// External pin model: gate levels and bursts of count edges.
// Assumes the bench raises start for one pclk with edges set.
module ddct_pins_model (
   // Clock
   input wire logic pclk,
   // Bench control
   input wire logic start,
   input wire logic [3:0] edges,
   input wire logic [1:0] gates,
   // Pins
   output logic [7:4] port_e_in,
   output logic external_count_in,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left = 4'h0;
   logic [4:0] ph = 5'h00;
   ////////////////////////////////////////
   // E5 and E6 sit on pull-ups
   assign port_e_in = {gates[1], 2'b11, gates[0]};
   // Edges 20 cycles apart so the sync stage sees each one
   always_ff @(posedge pclk) begin
      if (start) begin
         left <= edges;
         ph <= 5'h00;
      end else if (left != 4'h0) begin
         ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
         if (ph == 5'h13) left <= left - 4'h1;
      end
   end
   assign external_count_in = (left != 4'h0) && (ph >= 5'h0a);
   assign busy = left != 4'h0;
endmodule

// file: tb_top.sv
// Bench for the dual down-counter timer, driven over APB.
// Assumes ddct_top, its checker and the pin model are compiled first.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ddct_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, sample_rate_pulse_out, dio_latch_in, e;
   logic conversion_trigger, external_count_in, busy;
   logic [7:4] port_e_in, port_e_out, port_e_oe, port_e_dio_out, port_e_dio_oe;
   logic start = 1'b0;
   logic [3:0] edges = 4'h0;
   logic [1:0] gates = 2'b11;
   logic [23:0] v;
   int fail_count = 0;
   int checks = 0;
   int trig_n = 0;
   logic [7:0] tc [4] = '{8'h00, 8'h00, 8'h01, 8'h20};
   logic [7:0] ta [4] = '{8'h01, 8'h03, 8'h00, 8'h01};
   int td [4] = '{2, 5, 2, 5};
   ////////////////////////////////////////
   always #4 pclk = ~pclk;
   always @(posedge pclk) trig_n <= trig_n + int'(conversion_trigger === 1'b1);
   ddct_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port_e_in, .external_count_in,
      .sample_rate_pulse_out, .port_e_out, .port_e_oe, .port_e_dio_out,
      .port_e_dio_oe, .dio_latch_in, .conversion_trigger);
   ddct_pins_model u_pins (.pclk, .start, .edges, .gates, .port_e_in,
      .external_count_in, .busy);
   task automatic complete_run;
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   // Entered just after a rising edge; waits on pready, never on a count
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so a following call never reassigns in this step
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic lat(input logic c1, output logic [23:0] x);
      wr(ADDR_COUNTER_COMMAND, {c1, 7'h40});
      apb(1'b0, ADDR_DATA_LOW, 32'h0);
      x[7:0] = r[7:0];
      apb(1'b0, ADDR_DATA_MID, 32'h0);
      x[15:8] = r[7:0];
      apb(1'b0, ADDR_DATA_HIGH, 32'h0);
      x[23:16] = c1 ? 8'h00 : r[7:0];
   endtask
   task automatic ld(input logic c1, input logic [23:0] x);
      wr(ADDR_DATA_LOW, x[7:0]);
      wr(ADDR_DATA_MID, x[15:8]);
      if (!c1) wr(ADDR_DATA_HIGH, x[23:16]);
      wr(ADDR_COUNTER_COMMAND, {c1, 7'h02});
   endtask
   task automatic pulses(input logic [3:0] k);
      edges <= k;
      start <= 1'b1;
      @(posedge pclk) start <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask
   task automatic period(input logic [7:0] cfg, input logic [7:0] act, input int d);
      int n;
      int p;
      int t0;
      int w;
      w = cfg[0] ? SLOW_DIV : FAST_DIV;
      p = d * w;
      wr(ADDR_CONFIG, cfg);
      wr(ADDR_ANALOG_CTRL, act);
      ld(1'b0, 24'(d));
      wr(ADDR_COUNTER_COMMAND, 8'h04);
      t0 = trig_n;
      n = 0;
      while (sample_rate_pulse_out !== 1'b1 && n < 6000) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sample_rate_pulse_out === 1'b1 && n < 6000);
      chk("pulse width", n >= w - 1 && n <= w + 1, 1'b1);
      while (sample_rate_pulse_out !== 1'b1 && n < 6000) begin
         @(posedge pclk);
         n++;
      end
      chk("pulse period", n >= p - 2 && n <= p + 2, 1'b1);
      chk("trigger", trig_n != t0, act == 8'h01);
      // Disable only after the pulse ends, or it stands high while idle
      while (sample_rate_pulse_out === 1'b1) @(posedge pclk);
      wr(ADDR_COUNTER_COMMAND, 8'h08);
   endtask
   // The slow-clock case dominates the run time
   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped error", e, 1'b1);
      apb(1'b0, ADDR_COUNTER_COMMAND, 32'h0);
      chk("command read", r, 32'h0);
      wr(ADDR_DATA_HIGH, 8'h12);
      wr(ADDR_DATA_LOW, 8'h56);
      wr(ADDR_DATA_MID, 8'h34);
      wr(ADDR_COUNTER_COMMAND, 8'h02);
      repeat (200) @(posedge pclk);
      lat(1'b0, v);
      chk("loaded c0", v, 24'h123456);
      wr(ADDR_COUNTER_COMMAND, 8'h04);
      repeat (200) @(posedge pclk);
      apb(1'b0, ADDR_DATA_MID, 32'h0);
      chk("held latch", r[7:0], 8'h34);
      wr(ADDR_COUNTER_COMMAND, 8'h08);
      wr(ADDR_COUNTER_COMMAND, 8'h01);
      lat(1'b0, v);
      chk("cleared c0", v, 24'h0);
      ld(1'b1, 24'h00abcd);
      wr(ADDR_COUNTER_COMMAND, 8'h84);
      lat(1'b1, v);
      chk("c1 latch", v > 24'habc0 && v <= 24'habcd, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", r, 32'h2);
      wr(ADDR_COUNTER_COMMAND, 8'h88);
      foreach (td[i]) period(tc[i], ta[i], td[i]);
      wr(ADDR_CONFIG, 8'h20);
      gates <= 2'b10;
      ld(1'b0, 24'h000100);
      wr(ADDR_COUNTER_COMMAND, 8'h10);
      wr(ADDR_COUNTER_COMMAND, 8'h04);
      repeat (100) @(posedge pclk);
      lat(1'b0, v);
      chk("gated hold", v, 24'h000100);
      wr(ADDR_COUNTER_COMMAND, 8'h20);
      repeat (120) @(posedge pclk);
      lat(1'b0, v);
      chk("ungated run", v < 24'h100 && v > 24'hf0, 1'b1);
      wr(ADDR_COUNTER_COMMAND, 8'h08);
      gates <= 2'b11;
      wr(ADDR_CONFIG, 8'h24);
      ld(1'b1, 24'h000003);
      wr(ADDR_COUNTER_COMMAND, 8'h84);
      chk("port E enable", port_e_oe, 4'h4);
      pulses(4'd3);
      lat(1'b1, v);
      chk("ext count", v, 24'h0);
      chk("event out high", port_e_out[6], 1'b1);
      pulses(4'd1);
      lat(1'b1, v);
      chk("event reload", v, 24'h3);
      chk("event out low", port_e_out[6], 1'b0);
      wr(ADDR_CONFIG, 8'h04);
      ld(1'b1, 24'h001000);
      chk("DIO owns port E", port_e_dio_oe, 4'hf);
      chk("DIO out flag", port_e_dio_out, 4'hf);
      repeat (240) @(posedge pclk);
      lat(1'b1, v);
      chk("onboard clock", v < 24'h1000 && v > 24'h0fe0, 1'b1);
      complete_run();
   end
endmodule
